// ===== verilog/cscp_pkg.sv
// constants, carriers and state types for the converter serial control port
package cscp_pkg;

  // ---------------------------------------------------------------
  // frame geometry
  // ---------------------------------------------------------------
  localparam int         CSCP_WORD_BITS  = 16;
  localparam logic [4:0] CSCP_LAST_BIT   = 5'h10;   // sixteenth falling edge
  localparam logic [4:0] CSCP_FIRST_BIT  = 5'h01;
  localparam logic [4:0] CSCP_CNT_STEP   = 5'h01;
  localparam logic [15:0] CSCP_CTRL_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // link timing limits (kept by the host, recorded here)
  // ---------------------------------------------------------------
  localparam int CSCP_SCLK_MAX_KHZ   = 20000;
  localparam int CSCP_UPDATE_DIVISOR = 16;
  localparam int CSCP_UPDATE_MAX_KHZ = CSCP_SCLK_MAX_KHZ / CSCP_UPDATE_DIVISOR;

  // ---------------------------------------------------------------
  // state carriers, one per clock edge
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] shift;
    logic [4:0]  count;
    logic        frame_tog;
  } cscp_shift_t;

  typedef struct packed {
    logic [15:0] word;
    logic        commit_tog;
    logic        error_tog;
    logic        handled_tog;
  } cscp_commit_t;

  typedef struct packed {
    logic [15:0] ctrl_word;
    logic [2:0]  commit_sync;
    logic [2:0]  error_sync;
    logic        ctrl_update;
    logic        frame_error;
  } cscp_sys_t;

endpackage : cscp_pkg

// ===== verilog/cscp_port.sv
// serial control port: shifter on the link clock, control register on sys_clk
//
// Function
// [R01] select falling arms a 16-bit frame
// [R02] msb first, one bit per falling edge
// [R03] commit on rising edge after sixteenth bit
// [R04] early select release is error, no update; error only if a rising edge follows the release
// [R05] host updates no faster than sclk/16
// [R06] control register holds until commit
`timescale 1ns/1ps
module cscp_port
  import cscp_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        serial_clk,
  input  wire logic        sel_n,
  input  wire logic        serial_control_in,
  output logic [15:0]      ctrl_word,
  output logic             ctrl_update,
  output logic             frame_error
);

  // ---------------------------------------------------------------
  // frame start flag
  // ---------------------------------------------------------------
  logic         fresh;
  cscp_shift_t  sh;
  cscp_shift_t  next_sh;
  cscp_commit_t cm;
  cscp_commit_t next_cm;
  cscp_sys_t    st;
  cscp_sys_t    next_st;

  // one serial bit into the low end, so the first bit ends up as the msb
  function automatic logic [15:0] shift_in(input logic [15:0] word, input logic bit_in);
    return {word[14:0], bit_in};
  endfunction : shift_in

  // a toggle has landed once the last two sync stages differ
  function automatic logic toggled(input logic [2:0] sync);
    return sync[2] ^ sync[1];
  endfunction : toggled

  // set while select is high, so the link clock may stop between frames
  // [R01] arm on select
  always_ff @(negedge serial_clk or negedge rst_n or posedge sel_n)
  begin
    if (!rst_n)
      fresh <= 1'b1;
    else if (sel_n)
      fresh <= 1'b1;
    else
      fresh <= 1'b0;
  end

  // ---------------------------------------------------------------
  // shifter on falling serial clock
  // ---------------------------------------------------------------
  // bits past the sixteenth are ignored, the count saturates
  always_comb
  begin
    next_sh = sh;
    if (!sel_n)
    begin
      // [R01] new frame count
      if (fresh)
      begin
        next_sh.shift     = shift_in(sh.shift, serial_control_in);
        next_sh.count     = CSCP_FIRST_BIT;
        // taken from the commit side: a cut frame that never saw a rising
        // edge is dropped instead of cancelling this frame's pending flag
        next_sh.frame_tog = ~cm.handled_tog;
      end
      // [R02] msb first shift
      else if (sh.count != CSCP_LAST_BIT)
      begin
        next_sh.shift = shift_in(sh.shift, serial_control_in);
        next_sh.count = sh.count + CSCP_CNT_STEP;
      end
    end
  end

  always_ff @(negedge serial_clk or negedge rst_n)
  begin
    if (!rst_n)
      sh <= '0;
    else
      sh <= next_sh;
  end

  // ---------------------------------------------------------------
  // commit on rising serial clock
  // ---------------------------------------------------------------
  // word is held here apart from the shifter, so sys side reads a stable copy
  always_comb
  begin
    next_cm = cm;
    if (sh.frame_tog != cm.handled_tog)
    begin
      // [R03] full word commit
      if (sh.count == CSCP_LAST_BIT)
      begin
        next_cm.word        = sh.shift;
        next_cm.commit_tog  = ~cm.commit_tog;
        next_cm.handled_tog = sh.frame_tog;
      end
      // [R04] short frame dropped
      else if (sel_n)
      begin
        next_cm.error_tog   = ~cm.error_tog;
        next_cm.handled_tog = sh.frame_tog;
      end
    end
  end

  always_ff @(posedge serial_clk or negedge rst_n)
  begin
    if (!rst_n)
      cm <= '0;
    else
      cm <= next_cm;
  end

  // ---------------------------------------------------------------
  // system clock side
  // ---------------------------------------------------------------
  // toggles cross by two flops; the word is quiet for 16 link clocks after
  // each toggle, far longer than the synchroniser delay
  always_comb
  begin
    next_st             = st;
    next_st.ctrl_update = 1'b0;
    next_st.frame_error = 1'b0;
    next_st.commit_sync = {st.commit_sync[1:0], cm.commit_tog};
    next_st.error_sync  = {st.error_sync[1:0], cm.error_tog};
    // [R06] load only on commit
    if (toggled(st.commit_sync))
    begin
      next_st.ctrl_word   = cm.word;
      next_st.ctrl_update = 1'b1;
    end
    // [R04] report dropped frame
    if (toggled(st.error_sync))
      next_st.frame_error = 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st           <= '0;
      st.ctrl_word <= CSCP_CTRL_RESET;
    end
    else if (clk_en)
      st <= next_st;
  end

  assign ctrl_word   = st.ctrl_word;
  assign ctrl_update = st.ctrl_update;
  assign frame_error = st.frame_error;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_full_pending;
    (sh.frame_tog != cm.handled_tog) && (sh.count == CSCP_LAST_BIT);
  endsequence

  sequence s_short_release;
    (sh.frame_tog != cm.handled_tog) && (sh.count != CSCP_LAST_BIT) && sel_n;
  endsequence

  // [R01] count starts at one
  property p_arm;
    @(negedge serial_clk) disable iff (!rst_n)
      (fresh && !sel_n) |=> (sh.count == CSCP_FIRST_BIT);
  endproperty
  a_arm: assert property (p_arm) else $error("frame did not start at count one"); // [R01]

  // [R02] msb first shift
  property p_shift;
    @(negedge serial_clk) disable iff (!rst_n)
      (!fresh && !sel_n && sh.count != CSCP_LAST_BIT)
      |=> (sh.shift == {$past(sh.shift[14:0]), $past(serial_control_in)});
  endproperty
  a_shift: assert property (p_shift) else $error("serial bit not shifted in msb first"); // [R02]

  // [R03] full word commits
  property p_commit;
    @(posedge serial_clk) disable iff (!rst_n)
      s_full_pending |=> (cm.commit_tog != $past(cm.commit_tog)) && (cm.word == $past(sh.shift));
  endproperty
  a_commit: assert property (p_commit) else $error("full word not committed"); // [R03]

  // [R04] short frame dropped
  property p_short;
    @(posedge serial_clk) disable iff (!rst_n)
      s_short_release |=> $stable(cm.commit_tog) && $stable(cm.word) && (cm.error_tog != $past(cm.error_tog));
  endproperty
  a_short: assert property (p_short) else $error("short frame not flagged as error"); // [R04]

  // [R06] register holds between commits
  property p_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      !(clk_en && st.commit_sync[2] != st.commit_sync[1]) |=> $stable(ctrl_word) && !ctrl_update;
  endproperty
  a_hold: assert property (p_hold) else $error("control word changed without commit"); // [R06]

  // [R06] commit loads register
  property p_load;
    @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && st.commit_sync[2] != st.commit_sync[1]) |=> ctrl_update && (ctrl_word == $past(cm.word));
  endproperty
  a_load: assert property (p_load) else $error("committed word not loaded"); // [R06]

  // [R01] word closes at sixteen
  property p_saturate;
    @(negedge serial_clk) disable iff (!rst_n)
      (!fresh && sh.count == CSCP_LAST_BIT) |=> $stable(sh.shift) && (sh.count == CSCP_LAST_BIT);
  endproperty
  a_saturate: assert property (p_saturate) else $error("bits past the sixteenth altered the word"); // [R01]

  // [R03] single cycle update
  property p_pulse;
    @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && ctrl_update) |=> !ctrl_update;
  endproperty
  a_pulse: assert property (p_pulse) else $error("update pulse longer than one cycle"); // [R03]

  // [R04] error reaches system side
  property p_error;
    @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && st.error_sync[2] != st.error_sync[1]) |=> frame_error && $stable(ctrl_word);
  endproperty
  a_error: assert property (p_error) else $error("short frame error not reported"); // [R04]

endmodule : cscp_port

// ===== verification/cscp_host.sv
// host model: frames control words onto the serial link
`timescale 1ns/1ps
module cscp_host
(
  output logic serial_clk,
  output logic sel_n,
  output logic serial_control_in
);
  // link clock idles high, so the first edge in a frame falls
  initial
  begin
    serial_clk        = 1'b1;
    sel_n             = 1'b1;
    serial_control_in = 1'b0;
  end

  // one frame of n bits; bits past sixteen are junk
  task automatic frame(input logic [15:0] w, input int n);
    #3 sel_n = 1'b0;
    serial_control_in = w[15];
    for (int i = 1; i <= n; i++)
    begin
      #40 serial_clk = 1'b0;
      #40 serial_clk = 1'b1;
      serial_control_in = (i < 16) ? w[15-i] : ~serial_control_in;
    end
    // released line shows no stale value; one rising edge to decide
    #20 sel_n = 1'b1;
    serial_control_in = ~serial_control_in;
    #20 serial_clk = 1'b0;
    #40 serial_clk = 1'b1;
    #1280;
  endtask : frame
endmodule : cscp_host

// ===== verification/tb_top.sv
// self-checking bench for the converter serial control port
`timescale 1ns/1ps
module tb_top
  import cscp_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        clk_en  = 1'b0;
  logic        serial_clk;
  logic        sel_n;
  logic        serial_control_in;
  logic [15:0] ctrl_word;
  logic        ctrl_update;
  logic        frame_error;
  int          errors, compares, n_upd, n_err;

  always #5 sys_clk = ~sys_clk;

  cscp_host i_host (.serial_clk(serial_clk), .sel_n(sel_n), .serial_control_in(serial_control_in));
  cscp_port i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .serial_clk(serial_clk),
    .sel_n(sel_n), .serial_control_in(serial_control_in), .ctrl_word(ctrl_word),
    .ctrl_update(ctrl_update), .frame_error(frame_error));

  // count pulses; each must be seen in its single cycle
  always @(posedge sys_clk)
  begin
    if (ctrl_update === 1'b1) n_upd++;
    if (frame_error === 1'b1) n_err++;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test

  task automatic run(input logic [15:0] w, input int n, input int eu, input int ee);
    n_upd = 0;
    n_err = 0;
    i_host.frame(w, n);
    check(16'(n_upd), 16'(eu));
    check(16'(n_err), 16'(ee));
  endtask : run

  task automatic t_full;
    run(16'h8001, 16, 1, 0);
    check(ctrl_word, 16'h8001);
  endtask : t_full

  task automatic t_short;
    run(16'hffff, 15, 0, 1);
    check(ctrl_word, 16'h8001);
  endtask : t_short

  task automatic t_hold;
    fork
      run(16'h00ff, 16, 1, 0);
      #700 check(ctrl_word, 16'h8001);
    join
    check(ctrl_word, 16'h00ff);
  endtask : t_hold

  task automatic t_extra;
    run(16'h1234, 17, 1, 0);
    check(ctrl_word, 16'h1234);
  endtask : t_extra

  // frozen system side delays the commit, it must not lose it
  task automatic t_frozen;
    @(posedge sys_clk) clk_en <= 1'b0;
    run(16'h5a3c, 16, 0, 0);
    check(ctrl_word, 16'h1234);
    @(posedge sys_clk) clk_en <= 1'b1;
    repeat (10) @(posedge sys_clk);
    check(ctrl_word, 16'h5a3c);
  endtask : t_frozen

  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst_n  <= 1'b1;
    clk_en <= 1'b1;
    @(posedge sys_clk);
    check(ctrl_word, CSCP_CTRL_RESET);
    t_full;
    t_short;
    t_hold;
    t_extra;
    t_frozen;
    stop_test;
  end

  // watchdog well past the few frames above
  initial
  begin
    #200000;
    errors++;
    stop_test;
  end
endmodule : tb_top
